// file: exc_front_defines.svh
// Offsets, field positions and constants of the exception front end.
// Assumes big-endian bit numbering: spec bit n is vector bit 31-n.
`ifndef EXC_FRONT_DEFINES_SVH
`define EXC_FRONT_DEFINES_SVH
`define OFF_RESUME    8'h00
`define OFF_MSTATE    8'h04
`define OFF_CRESUME   8'h08
`define OFF_CMSTATE   8'h0C
`define OFF_CTRL      8'h10
`define OFF_STATUS    8'h14
`define CTRL_TRACE    0
`define CTRL_CRIT     1
`define ASYNC_CRIT    1
`define SV_B0         31
`define SV_CR_HI      31
`define SV_CR_LO      28
`define SV_MID_HI     26
`define SV_MID_LO     22
`define SV_B12        19
`define SV_B13        18
`define SV_B14        17
`define SV_B15        16
`define SV_FLAG_HI    19
`define SV_FLAG_LO    16
`define SV_HI_HI      31
`define SV_HI_LO      16
`define SV_LO_HI      15
`define SV_LO_LO      0
`define INSTR_STEP    32'h0000_0004
`define ZERO16        16'h0000
`define ZERO32        32'h0000_0000
`define SUB_INSTRUCTION_TRANSLATION_BUFFER      4'h0
`define SUB_ISI       4'h1
`define SUB_SYSCALL   4'h2
`define SUB_DATA_TRANSLATION_BUFFER_A    4'h8
`define SUB_DATA_TRANSLATION_BUFFER_B    4'hB
`endif

// file: exc_front_pkg.sv
// Types shared by the exception front end.
// Assumes nothing of its surroundings.
package exc_front_pkg;
    typedef enum logic [3:0] {
        C_NONE   = 4'h0,
        C_HRESET = 4'h1,
        C_MCHECK = 4'h2,
        C_SRESET = 4'h3,
        C_ASYNC  = 4'h4,
        C_FETCH  = 4'h5,
        C_DISP   = 4'h6,
        C_TRACE  = 4'h7
    } cause_t;

    typedef struct packed {
        logic [31:0] ra;
        logic [31:0] ms;
        logic [31:0] cra;
        logic [31:0] cms;
        logic [1:0]  ctrl;
        logic        sreset_p;
        logic [3:0]  mc_p;
        logic [3:0]  async_p;
        logic [1:0]  fetch_p;
        logic        gate;
        logic        chk;
        logic        take_v;
        cause_t      cause;
        logic [3:0]  sub;
        logic [31:0] next_instruction_address;
        logic [31:0] msr_o;
        logic        rest_v;
        logic        rest_hi;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        halt_disp;
        logic        halt_comp;
    } state_t;
endpackage

// file: core_exception_front_end.sv
// Exception front end: priority, take timing, save/restore pairs.
// Assumes core inputs synchronous to pclk; async requests pre-masked.
//
// Local design decisions: the address map and register access over APB.
`include "exc_front_defines.svh"

module core_exception_front_end #(
    parameter int RI_BIT = 1,
    parameter int ME_BIT = 12
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [7:0]             paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   hreset_req,
    input  wire logic                   mcp_in,
    input  wire logic                   tea_in,
    input  wire logic                   dpe_in,
    input  wire logic                   ape_in,
    input  wire logic                   sreset_req,
    input  wire logic [3:0]             async_req,
    input  wire logic                   instruction_translation_buffer_miss,
    input  wire logic                   isi_fault,
    input  wire logic [31:0]            fetch_addr,
    input  wire logic [11:0]            disp_exc,
    input  wire logic [31:0]            disp_addr,
    input  wire logic [15:0]            disp_status,
    input  wire logic                   older_done,
    input  wire logic                   sq_empty,
    input  wire logic                   sq_cancel,
    input  wire logic                   next_signaled,
    input  wire logic                   regs_written,
    input  wire logic                   cbq_removed,
    input  wire logic                   pipe_empty,
    input  wire logic [31:0]            next_addr,
    input  wire logic [31:0]            msr_in,
    input  wire logic [3:0]             cr0_in,
    input  wire logic                   tlb_key,
    input  wire logic                   tlb_way,
    input  wire logic                   tlb_store,
    input  wire logic                   rfi_exec,
    input  wire logic                   rfci_exec,
    output logic                        take_valid,
    output exc_front_pkg::cause_t       take_cause,
    output logic [3:0]                  take_sub,
    output logic                        halt_dispatch,
    output logic                        halt_completion,
    output logic                        checkstop,
    output logic [31:0]                 next_instruction_address,
    output logic                        nia_valid,
    output logic [31:0]                 msr_restore,
    output logic                        msr_restore_hi_only
);

    exc_front_pkg::state_t st_reg;
    exc_front_pkg::state_t st_next;

    logic        done_now;
    logic        recov;
    logic [3:0]  mc_vec;
    logic [3:0]  async_en;
    logic [3:0]  async_idx;
    logic [3:0]  disp_idx;
    logic        setup;
    logic        wr_acc;

    function automatic logic [3:0] first12(input logic [11:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Normal layout: status high half, machine state low half
    function automatic logic [31:0] norm_save(input logic [15:0] s,
                                              input logic [31:0] m);
        return {s, m[`SV_LO_HI:`SV_LO_LO]};
    endfunction

    function automatic logic [31:0] mc_save(input logic [31:0] m,
                                            input logic [3:0]  f);
        logic [31:0] r;
        r = `ZERO32;
        r[`SV_B0] = m[`SV_B0];
        r[`SV_MID_HI:`SV_MID_LO] = m[`SV_MID_HI:`SV_MID_LO];
        r[`SV_FLAG_HI:`SV_FLAG_LO] = f;
        r[`SV_LO_HI:`SV_LO_LO] = m[`SV_LO_HI:`SV_LO_LO];
        return r;
    endfunction

    function automatic logic [31:0] tlb_save(input logic [31:0] m,
                                             input logic [3:0]  cr,
                                             input logic        key,
                                             input logic        instr,
                                             input logic        way,
                                             input logic        store);
        logic [31:0] r;
        r = `ZERO32;
        r[`SV_CR_HI:`SV_CR_LO] = cr;
        r[`SV_MID_HI:`SV_MID_LO] = m[`SV_MID_HI:`SV_MID_LO];
        r[`SV_B12] = key;
        r[`SV_B13] = instr;
        r[`SV_B14] = way;
        r[`SV_B15] = store;
        r[`SV_LO_HI:`SV_LO_LO] = m[`SV_LO_HI:`SV_LO_LO];
        return r;
    endfunction

    assign done_now = regs_written & cbq_removed;
    assign recov    = sq_empty & ~sq_cancel
                    & (~next_signaled | done_now)
                    & msr_in[RI_BIT];
    assign mc_vec   = {mcp_in, tea_in, dpe_in, ape_in};
    assign async_en = async_req
                    & {2'b11, st_reg.ctrl[`CTRL_CRIT], 1'b1};
    assign async_idx = first12({8'h00, st_reg.async_p});
    assign disp_idx  = first12(disp_exc);
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & st_reg.pready
                  & pwrite & ~st_reg.pslverr;

    always_comb begin
        st_next = st_reg;
        st_next.take_v  = 1'b0;
        st_next.cause   = exc_front_pkg::C_NONE;
        st_next.sub     = 4'h0;
        st_next.rest_v  = 1'b0;
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;

        // Register bus: decode in setup, answer in access
        if (setup) begin
            st_next.pready = 1'b1;
            case (paddr)
                `OFF_RESUME:  st_next.prdata = st_reg.ra;
                `OFF_MSTATE:  st_next.prdata = st_reg.ms;
                `OFF_CRESUME: st_next.prdata = st_reg.cra;
                `OFF_CMSTATE: st_next.prdata = st_reg.cms;
                `OFF_CTRL: begin
                    st_next.prdata = {30'h0000_0000, st_reg.ctrl};
                end
                `OFF_STATUS: begin
                    st_next.prdata = {18'h0_0000, st_reg.chk,
                                      st_reg.gate, st_reg.sreset_p,
                                      st_reg.fetch_p, st_reg.async_p,
                                      st_reg.mc_p, recov};
                end
                default: begin
                    st_next.prdata  = `ZERO32;
                    st_next.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                `OFF_RESUME:  st_next.ra   = pwdata;
                `OFF_MSTATE:  st_next.ms   = pwdata;
                `OFF_CRESUME: st_next.cra  = pwdata;
                `OFF_CMSTATE: st_next.cms  = pwdata;
                `OFF_CTRL:    st_next.ctrl = pwdata[1:0];
                default: ;
            endcase
        end

        // Collect pending conditions
        st_next.sreset_p = st_reg.sreset_p | sreset_req;
        st_next.mc_p     = st_reg.mc_p | mc_vec;
        st_next.async_p  = st_reg.async_p | async_en;
        st_next.fetch_p  = st_reg.fetch_p | {isi_fault, instruction_translation_buffer_miss};
        if (|st_reg.async_p && ((done_now && ~|disp_exc)
                                || pipe_empty)) begin
            st_next.gate = 1'b1;
        end

        // Priority chain; hardware save beats a bus write
        if (hreset_req) begin
            st_next = st_next;
            st_next.sreset_p = 1'b0;
            st_next.mc_p     = 4'h0;
            st_next.async_p  = 4'h0;
            st_next.fetch_p  = 2'b00;
            st_next.gate     = 1'b0;
            st_next.chk      = 1'b0;
            st_next.take_v   = 1'b1;
            st_next.cause    = exc_front_pkg::C_HRESET;
        end else if (st_reg.chk) begin
            st_next.gate = st_reg.gate;
        end else if (|st_reg.mc_p) begin
            if (msr_in[ME_BIT]) begin
                st_next.take_v  = 1'b1;
                st_next.cause   = exc_front_pkg::C_MCHECK;
                st_next.ra      = next_addr;
                st_next.ms      = mc_save(msr_in, st_reg.mc_p);
                st_next.mc_p    = mc_vec;
                st_next.fetch_p = 2'b00;
            end else begin
                st_next.chk = 1'b1;
            end
        end else if (st_reg.sreset_p && recov) begin
            st_next.take_v   = 1'b1;
            st_next.cause    = exc_front_pkg::C_SRESET;
            st_next.ra       = next_addr;
            st_next.ms       = norm_save(`ZERO16, msr_in);
            st_next.sreset_p = sreset_req;
            st_next.fetch_p  = 2'b00;
        end else if (|disp_exc && older_done) begin
            // Excepting instruction wins over async; async stays
            st_next.take_v  = 1'b1;
            st_next.cause   = exc_front_pkg::C_DISP;
            st_next.sub     = disp_idx;
            st_next.fetch_p = 2'b00;
            st_next.gate    = 1'b0;
            if (disp_idx == `SUB_SYSCALL) begin
                st_next.ra = disp_addr + `INSTR_STEP;
            end else begin
                st_next.ra = disp_addr;
            end
            if (disp_idx == `SUB_DATA_TRANSLATION_BUFFER_A || disp_idx == `SUB_DATA_TRANSLATION_BUFFER_B) begin
                st_next.ms = tlb_save(msr_in, cr0_in, tlb_key, 1'b0,
                                      tlb_way, tlb_store);
            end else begin
                st_next.ms = norm_save(disp_status, msr_in);
            end
        end else if (st_reg.gate && recov) begin
            st_next.take_v  = 1'b1;
            st_next.cause   = exc_front_pkg::C_ASYNC;
            st_next.sub     = async_idx;
            st_next.gate    = 1'b0;
            st_next.fetch_p = 2'b00;
            st_next.async_p[async_idx[1:0]] = async_en[async_idx[1:0]];
            if (async_idx == `ASYNC_CRIT) begin
                st_next.cra = next_addr;
                st_next.cms = {`ZERO16, msr_in[`SV_LO_HI:`SV_LO_LO]};
            end else begin
                st_next.ra = next_addr;
                st_next.ms = norm_save(`ZERO16, msr_in);
            end
        end else if (|st_reg.fetch_p && pipe_empty && recov) begin
            st_next.take_v  = 1'b1;
            st_next.cause   = exc_front_pkg::C_FETCH;
            st_next.ra      = fetch_addr;
            st_next.fetch_p = 2'b00;
            if (st_reg.fetch_p[0]) begin
                st_next.sub = `SUB_INSTRUCTION_TRANSLATION_BUFFER;
                st_next.ms  = tlb_save(msr_in, cr0_in, tlb_key, 1'b1,
                                       tlb_way, 1'b0);
            end else begin
                st_next.sub = `SUB_ISI;
                st_next.ms  = norm_save(`ZERO16, msr_in);
            end
        end else if (st_reg.ctrl[`CTRL_TRACE] && done_now
                     && ~|disp_exc) begin
            st_next.take_v = 1'b1;
            st_next.cause  = exc_front_pkg::C_TRACE;
            st_next.ra     = next_addr;
            st_next.ms     = norm_save(`ZERO16, msr_in);
        end

        // Return instructions
        if (rfi_exec) begin
            st_next.next_instruction_address     = st_reg.ra;
            st_next.msr_o   = st_reg.ms;
            st_next.rest_v  = 1'b1;
            st_next.rest_hi = 1'b0;
        end else if (rfci_exec) begin
            st_next.next_instruction_address     = st_reg.cra;
            st_next.msr_o   = st_reg.cms;
            st_next.rest_v  = 1'b1;
            st_next.rest_hi = 1'b1;
        end

        st_next.halt_disp = |st_next.fetch_p | st_next.chk
                          | st_next.gate;
        st_next.halt_comp = st_next.gate | st_next.chk;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata              = st_reg.prdata;
    assign pready              = st_reg.pready;
    assign pslverr             = st_reg.pslverr;
    assign take_valid          = st_reg.take_v;
    assign take_cause          = st_reg.cause;
    assign take_sub            = st_reg.sub;
    assign halt_dispatch       = st_reg.halt_disp;
    assign halt_completion     = st_reg.halt_comp;
    assign checkstop           = st_reg.chk;
    assign next_instruction_address                 = st_reg.next_instruction_address;
    assign nia_valid           = st_reg.rest_v;
    assign msr_restore         = st_reg.msr_o;
    assign msr_restore_hi_only = st_reg.rest_hi;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_HRESET_TAKE: assert property (
        hreset_req |=> take_valid
                       && take_cause == exc_front_pkg::C_HRESET
                       && !checkstop)
        else $error("hard reset not taken next cycle");

    AST_MC_TAKE: assert property (
        !hreset_req && !st_reg.chk && |st_reg.mc_p && msr_in[ME_BIT]
        |=> take_valid && take_cause == exc_front_pkg::C_MCHECK)
        else $error("enabled machine check not taken");

    AST_CHECKSTOP: assert property (
        !hreset_req && !st_reg.chk && |st_reg.mc_p && !msr_in[ME_BIT]
        |=> checkstop && !take_valid ##1 halt_dispatch)
        else $error("disabled machine check did not checkstop");

    AST_SRESET_RECOV: assert property (
        take_valid && take_cause == exc_front_pkg::C_SRESET
        |-> $past(recov) && $past(st_reg.sreset_p))
        else $error("soft reset taken while nonrecoverable");

    AST_ASYNC_RECOV: assert property (
        take_valid && take_cause == exc_front_pkg::C_ASYNC
        |-> $past(recov) && $past(msr_in[RI_BIT]))
        else $error("async exception taken while nonrecoverable");

    AST_ASYNC_HALT: assert property (
        !hreset_req && |st_reg.async_p && done_now && ~|disp_exc
        && !(st_reg.gate && recov) |=> halt_completion)
        else $error("completion not halted with async pending");

    AST_FETCH_HALT: assert property (
        !hreset_req && isi_fault |=> halt_dispatch)
        else $error("dispatch not halted on fetch fault");

    AST_FETCH_DROP: assert property (
        take_valid && take_cause == exc_front_pkg::C_DISP
        |-> st_reg.fetch_p == $past(2'b00 & {isi_fault, instruction_translation_buffer_miss}))
        else $error("fetch fault kept after drain exception");

    AST_INSTRUCTION_TRANSLATION_BUFFER_SAVE: assert property (
        take_valid && take_cause == exc_front_pkg::C_FETCH
        && take_sub == `SUB_INSTRUCTION_TRANSLATION_BUFFER
        |-> st_reg.ms[`SV_B13] && !st_reg.ms[`SV_B15]
            && st_reg.ms[`SV_B14] == $past(tlb_way))
        else $error("instruction miss save layout wrong");

    AST_SYSCALL_ADDR: assert property (
        take_valid && take_cause == exc_front_pkg::C_DISP
        && take_sub == `SUB_SYSCALL
        |-> st_reg.ra == $past(disp_addr) + `INSTR_STEP)
        else $error("system call resume address wrong");

    AST_CRIT_SAVE: assert property (
        take_valid && take_cause == exc_front_pkg::C_ASYNC
        && take_sub == `ASYNC_CRIT
        |-> st_reg.cms[`SV_HI_HI:`SV_HI_LO] == `ZERO16
            && st_reg.cms[`SV_LO_HI:`SV_LO_LO] == $past(msr_in[15:0]))
        else $error("critical save layout wrong");

    AST_RFCI_NIA: assert property (
        rfci_exec && !rfi_exec
        |=> nia_valid && msr_restore_hi_only
            && next_instruction_address == $past(st_reg.cra))
        else $error("critical return address wrong");

    COV_MC: cover property (
        take_valid && take_cause == exc_front_pkg::C_MCHECK);
    COV_ASYNC_GATED: cover property (
        halt_completion ##[1:20] take_valid
        && take_cause == exc_front_pkg::C_ASYNC);
    COV_FETCH: cover property (
        take_valid && take_cause == exc_front_pkg::C_FETCH);
    COV_TRACE: cover property (
        take_valid && take_cause == exc_front_pkg::C_TRACE);

endmodule // core_exception_front_end

// file: core_pipe_model.sv
// Model of the core pipeline beside the exception front end.
// Assumes fault and retire come from the bench as one-cycle pulses.
module core_pipe_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        take_valid,
    input  wire logic        retire,
    input  wire logic [11:0] fault,
    output logic      [11:0] disp_exc,
    output logic             older_done,
    output logic             regs_written,
    output logic             cbq_removed,
    output logic             pipe_empty,
    output logic             sq_empty
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] held;
    // Pending fault dropped on any take
    assign disp_exc = held & {12{~take_valid}};
    assign older_done = 1'b1;
    assign sq_empty = 1'b1;
    assign pipe_empty = (held == 12'h000) && !retire;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= 12'h000;
            regs_written <= 1'b0;
            cbq_removed <= 1'b0;
        end else begin
            held <= take_valid ? 12'h000 : (held | fault);
            regs_written <= retire;
            cbq_removed <= retire;
        end
    end
endmodule // core_pipe_model

// file: core_exception_front_end_test.sv
// Register-level bench of the exception front end.
// Assumes the pipeline model and the design headers are compiled first.
`include "exc_front_defines.svh"
module core_exception_front_end_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] M = 32'hA5C0_1A3E;
    localparam logic [31:0] N = 32'h0000_4000;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic hreset_req = 0, mcp_in = 0, tea_in = 0, dpe_in = 0, ape_in = 0;
    logic sreset_req = 0, instruction_translation_buffer_miss = 0, isi_fault = 0, sq_cancel = 0;
    logic next_signaled = 0, tlb_key = 0, tlb_way = 0, tlb_store = 0;
    logic retire = 0, rfi_exec = 0, rfci_exec = 0, er;
    logic [7:0] paddr = 8'h00;
    logic [3:0] async_req = 4'h0, cr0_in = 4'h0, take_sub;
    logic [11:0] fault = 12'h000, disp_exc;
    logic [15:0] disp_status = 16'h0000;
    logic [31:0] pwdata = 32'h0, fetch_addr = 32'h0, disp_addr = 32'h0;
    logic [31:0] next_addr = 32'h0, msr_in = 32'h0, rd;
    logic [31:0] prdata, next_instruction_address, msr_restore;
    exc_front_pkg::cause_t take_cause;
    logic pready, pslverr, take_valid, halt_dispatch, halt_completion;
    logic checkstop, nia_valid, msr_restore_hi_only, older_done;
    logic regs_written, cbq_removed, pipe_empty, sq_empty;
    int mismatches = 0, cmp_count = 0;
    core_exception_front_end dut (.*);
    core_pipe_model pipe (.*);
    always #20 pclk = ~pclk;
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task take(input logic [3:0] c, input logic [3:0] s);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (take_valid !== 1'b1 && n < 16);
        chk({28'h0, take_cause}, {28'h0, c});
        if (s != 4'hF) chk({28'h0, take_sub}, {28'h0, s});
        @(posedge pclk);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] m, e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task fault_run(input int i, input logic [31:0] ra, ms);
        fault <= 12'h001 << i;
        @(posedge pclk);
        fault <= 12'h000;
        take(4'h6, i[3:0]);
        rdchk(`OFF_RESUME, 32'hFFFF_FFFF, ra);
        rdchk(`OFF_MSTATE, 32'hFFFF_FFFF, ms);
    endtask
    task ret(input logic f, input logic [31:0] a, m);
        rfi_exec <= !f;
        rfci_exec <= f;
        @(posedge pclk);
        rfi_exec <= 1'b0;
        rfci_exec <= 1'b0;
        @(negedge pclk);
        chk({31'h0, nia_valid}, 32'h1);
        chk(next_instruction_address, a);
        chk({31'h0, msr_restore_hi_only}, {31'h0, f});
        chk({16'h0, msr_restore[15:0]}, {16'h0, m[15:0]});
        @(posedge pclk);
    endtask
    task complete_run;
        $display("mismatches %0d of %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 16; a += 4) rdchk(a[7:0], 32'hFFFF_FFFF, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, `OFF_CTRL, 32'h2);
        msr_in <= M & ~32'h2;
        next_addr <= N;
        {mcp_in, tea_in, sreset_req} <= 3'h7;
        @(posedge pclk);
        {mcp_in, tea_in, sreset_req} <= 3'h0;
        take(4'h2, 4'hF);
        rdchk(`OFF_MSTATE, 32'hFFFF_FFFF, 32'h85CC_1A3C);
        rdchk(`OFF_RESUME, 32'hFFFF_FFFF, N);
        rdchk(`OFF_STATUS, 32'h0000_2801, 32'h0000_0800);
        msr_in <= M;
        take(4'h3, 4'hF);
        async_req <= 4'h2;
        @(posedge pclk);
        async_req <= 4'h0;
        take(4'h4, 4'h1);
        rdchk(`OFF_CRESUME, 32'hFFFF_FFFF, N);
        rdchk(`OFF_CMSTATE, 32'hFFFF_FFFF, 32'h0000_1A3E);
        msr_in <= M & ~32'h2;
        async_req <= 4'h4;
        @(posedge pclk);
        async_req <= 4'h0;
        repeat (4) @(posedge pclk);
        rdchk(`OFF_STATUS, 32'h0000_11E1, 32'h0000_1080);
        msr_in <= M;
        take(4'h4, 4'h2);
        {disp_addr, disp_status, cr0_in} <= {32'h2000, 16'hBEEF, 4'hA};
        {tlb_key, tlb_way, tlb_store} <= 3'h7;
        fault_run(2, 32'h0000_2004, 32'hBEEF_1A3E);
        fault_run(8, 32'h0000_2000, 32'hA5CB_1A3E);
        apb(1'b1, `OFF_CTRL, 32'h3);
        retire <= 1'b1;
        @(posedge pclk);
        retire <= 1'b0;
        take(4'h7, 4'hF);
        rdchk(`OFF_RESUME, 32'hFFFF_FFFF, N);
        fetch_addr <= 32'h0000_3000;
        instruction_translation_buffer_miss <= 1'b1;
        @(posedge pclk);
        instruction_translation_buffer_miss <= 1'b0;
        take(4'h5, 4'h0);
        rdchk(`OFF_RESUME, 32'hFFFF_FFFF, 32'h0000_3000);
        apb(1'b1, `OFF_RESUME, 32'h1234_5678);
        apb(1'b1, `OFF_MSTATE, 32'h0000_9ABC);
        ret(1'b0, 32'h1234_5678, 32'h0000_9ABC);
        apb(1'b1, `OFF_CRESUME, 32'h0000_5000);
        apb(1'b1, `OFF_CMSTATE, 32'h0000_00FF);
        ret(1'b1, 32'h0000_5000, 32'h0000_00FF);
        msr_in <= 32'h0000_0002;
        dpe_in <= 1'b1;
        @(posedge pclk);
        dpe_in <= 1'b0;
        @(posedge pclk);
        rdchk(`OFF_STATUS, 32'h0000_2000, 32'h0000_2000);
        hreset_req <= 1'b1;
        @(posedge pclk);
        hreset_req <= 1'b0;
        take(4'h1, 4'hF);
        rdchk(`OFF_STATUS, 32'h0000_2000, 32'h0000_0000);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        complete_run;
    end
endmodule // core_exception_front_end_test
